// ### rtl/byte_wide_host_port.v
// byte-wide parallel host port: mode straps, register map, message handshake
// assumes host pins are asynchronous and firmware signals share clock_in
//
// Notes on behaviour
// - strap pins read at reset release choose one of four host modes
// - only the latched mode operates; others ignored until next reset
// - external memory is offered only in serial host modes
// - download by parallel, serial, or autoboot; autoboot only in serial modes
// - parallel modes expose four byte registers chosen by two address bits
// - address 11 takes compressed bytes, 10 takes pcm bytes, both write only
// - address 00 is the message pipe, 01 is control and status
// - interrupt line pulled low in parallel modes while an outbound message waits
// - separate strobes ignored with select high; select and read low drive data
// - write starts with select and write low; address held stable
// - write ends and data latched on first rise of select or write
// - during reset all controls ignored and data bus released
// - message pipe has separate inbound and outbound byte registers
// - outbound ready bit 1 set by firmware write, cleared by host read
// - inbound busy bit 2 set by host write, cleared by firmware read
// - control bit 6 holds compressed channel in reset while one
// - control bit 5 holds pcm channel in reset while one
// - status bit 4 shows pcm buffer almost full
// - status bit 3 shows compressed buffer almost full
// - strobe-direction read drives data while select and data strobe are low; released on first rise
// - strobe-direction write latched on first rise of select or data strobe
`timescale 1ns/1ps
`include "host_port_defines.vh"
module byte_wide_host_port (
  input wire clock_in,
  input wire reset_n_in,
  // host pins
  input wire chip_select_n_in,
  input wire read_strobe_n_in,
  input wire write_strobe_n_in,
  input wire parallel_select_in,
  input wire [1:0] reg_addr_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n_out,
  output reg host_irq_n_oe_n_out,
  // firmware side
  input wire fw_outbound_write_in,
  input wire [7:0] fw_outbound_data_in,
  input wire fw_inbound_read_in,
  input wire fw_message_waiting_in,
  input wire pcm_buffer_almost_full_in,
  input wire compressed_buffer_almost_full_in,
  output reg [7:0] fw_inbound_data_out,
  output reg inbound_busy_out,
  output reg outbound_ready_out,
  output reg compressed_channel_reset_out,
  output reg pcm_channel_reset_out,
  output reg [7:0] pcm_byte_out,
  output reg pcm_byte_valid_out,
  output reg [7:0] compressed_byte_out,
  output reg compressed_byte_valid_out,
  output reg [2:0] host_mode_out,
  output reg ext_memory_enable_out,
  output reg autoboot_allowed_out
);
  // cycle states of the host access
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_WRITE = 3'b100;

  wire cs_n_s;
  wire rd_n_s;
  wire wr_n_s;
  wire psel_s;
  wire [1:0] addr_s;
  wire [7:0] data_s;
  wire [2:0] mode_w;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] addr_r;
  reg [7:0] wdata_r;
  reg [7:0] outbound_r;
  reg [7:0] inbound_r;
  reg inbound_busy_r;
  reg outbound_ready_r;
  reg cmp_rst_r;
  reg pcm_rst_r;
  reg read_ok;
  reg write_ok;
  reg write_end;
  reg read_end;
  reg host_read_msg;
  reg host_write_pulse;
  reg write_msg;
  reg write_ctrl;
  reg write_pcm;
  reg write_cmp;

  // control register read image
  function [7:0] status_image;
    input pcm_af;
    input cmp_af;
    input busy;
    input ready;
    begin
      status_image = 8'h00;
      status_image[`BIT_PCM_ALMOST_FULL] = pcm_af;
      status_image[`BIT_COMPRESSED_ALMOST_FULL] = cmp_af;
      status_image[`BIT_INBOUND_BUSY] = busy;
      status_image[`BIT_OUTBOUND_READY] = ready;
    end
  endfunction

  // true for the two serial host modes, which own the memory pins
  function serial_mode;
    input [2:0] mode;
    begin
      serial_mode = (mode == `MODE_I2C) || (mode == `MODE_SPI);
    end
  endfunction

  // true for the two parallel host modes, which own the byte bus
  function parallel_mode;
    input [2:0] mode;
    begin
      parallel_mode = (mode == `MODE_SEPARATE) || (mode == `MODE_STROBE_DIR);
    end
  endfunction

  // host pins pass the three-flop filter; straps settle while reset is held
  pin_sync #(
    .WIDTH(14),
    .INIT(14'h3f00)
  ) u_pin_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .pin_in({chip_select_n_in, read_strobe_n_in, write_strobe_n_in, parallel_select_in, reg_addr_in, data_in}),
    .level_out({cs_n_s, rd_n_s, wr_n_s, psel_s, addr_s, data_s})
  );

  // straps sampled at reset release
  mode_latch u_mode_latch (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .read_strap_in(rd_n_s),
    .write_strap_in(wr_n_s),
    .select_strap_in(psel_s),
    .mode_out(mode_w)
  );

  // qualify strobes by mode and chip select
  always @* begin
    read_ok = 1'b0;
    write_ok = 1'b0;
    // serial and unlatched modes leave both qualifiers low, so the bus is ignored
    if (mode_w == `MODE_SEPARATE) begin
      read_ok = !cs_n_s && !rd_n_s;
      write_ok = !cs_n_s && !wr_n_s;
    end else if (mode_w == `MODE_STROBE_DIR) begin
      // read pin doubles as direction, write pin as data strobe
      read_ok = !cs_n_s && !wr_n_s && rd_n_s;
      write_ok = !cs_n_s && !wr_n_s && !rd_n_s;
    end
  end

  // cycle state machine; other modes never leave idle
  always @* begin
    state_nxt = state_r;
    write_end = 1'b0;
    read_end = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (write_ok) begin
          state_nxt = ST_WRITE;
        end else if (read_ok) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (!read_ok) begin
          state_nxt = ST_IDLE;
          read_end = 1'b1;
        end
      end
      ST_WRITE: begin
        if (!write_ok) begin
          state_nxt = ST_IDLE; // first rise of select or strobe ends it
          write_end = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    host_read_msg = read_end && (addr_r == `ADDR_MESSAGE_PIPE);
    host_write_pulse = write_end;
    // one strobe per register for a finished host write
    write_msg = host_write_pulse && (addr_r == `ADDR_MESSAGE_PIPE);
    write_ctrl = host_write_pulse && (addr_r == `ADDR_HOST_CONTROL_STATUS);
    write_pcm = host_write_pulse && (addr_r == `ADDR_PCM_INPUT_PORT);
    write_cmp = host_write_pulse && (addr_r == `ADDR_COMPRESSED_INPUT_PORT);
  end

  // cycle tracking and capture of address and data
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      addr_r <= 2'h0;
      wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      // address is frozen for the whole cycle; a change mid-cycle cannot retarget it
      if (state_r == ST_IDLE) begin
        addr_r <= addr_s;
      end
      // data keeps following the filtered bus until select or the strobe is seen high
      if (write_ok) begin
        wdata_r <= data_s; // last value before select or the strobe rises
      end
    end
  end

  // message pipe, handshake flags and control bits
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      outbound_r <= 8'h00;
      inbound_r <= 8'h00;
      inbound_busy_r <= 1'b0;
      outbound_ready_r <= 1'b0;
      cmp_rst_r <= `CHANNEL_RESET_INIT;
      pcm_rst_r <= `CHANNEL_RESET_INIT;
    end else begin
      // outbound byte is only written by firmware; host writes never reach it
      if (fw_outbound_write_in) begin
        outbound_r <= fw_outbound_data_in;
      end
      // set wins over clear
      if (fw_outbound_write_in) begin
        outbound_ready_r <= 1'b1;
      end else if (host_read_msg) begin
        outbound_ready_r <= 1'b0;
      end
      // host write wins over a firmware read in the same cycle
      if (write_msg) begin
        inbound_r <= wdata_r;
        inbound_busy_r <= 1'b1;
      end else if (fw_inbound_read_in) begin
        inbound_busy_r <= 1'b0;
      end
      // channel reset bits take effect once the host write has finished
      if (write_ctrl) begin
        cmp_rst_r <= wdata_r[`BIT_COMPRESSED_RESET];
        pcm_rst_r <= wdata_r[`BIT_PCM_RESET];
      end
    end
  end

  // registered outputs toward firmware and host
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      data_out <= 8'h00;
      data_oe_n_out <= 1'b1;
      host_irq_n_oe_n_out <= 1'b1;
      fw_inbound_data_out <= 8'h00;
      inbound_busy_out <= 1'b0;
      outbound_ready_out <= 1'b0;
      compressed_channel_reset_out <= `CHANNEL_RESET_INIT;
      pcm_channel_reset_out <= `CHANNEL_RESET_INIT;
      pcm_byte_out <= 8'h00;
      pcm_byte_valid_out <= 1'b0;
      compressed_byte_out <= 8'h00;
      compressed_byte_valid_out <= 1'b0;
      host_mode_out <= `MODE_NONE;
      ext_memory_enable_out <= 1'b0;
      autoboot_allowed_out <= 1'b0;
    end else begin
      // read data, driven while the read cycle lasts
      data_oe_n_out <= !(state_nxt == ST_READ);
      // read image follows the frozen address, so it is steady while driven
      case (addr_r)
        `ADDR_MESSAGE_PIPE: data_out <= outbound_r;
        `ADDR_HOST_CONTROL_STATUS: data_out <= status_image(pcm_buffer_almost_full_in,
          compressed_buffer_almost_full_in, inbound_busy_r, outbound_ready_r);
        default: data_out <= 8'h00;
      endcase
      // pull the line low in parallel modes while a message waits
      host_irq_n_oe_n_out <= !(fw_message_waiting_in && parallel_mode(mode_w));
      // firmware-facing copies lag the internal flags by one cycle
      fw_inbound_data_out <= inbound_r;
      inbound_busy_out <= inbound_busy_r;
      outbound_ready_out <= outbound_ready_r;
      compressed_channel_reset_out <= cmp_rst_r;
      pcm_channel_reset_out <= pcm_rst_r;
      // data input ports, one pulse per host byte, dropped while channel held
      pcm_byte_valid_out <= write_pcm && !pcm_rst_r;
      compressed_byte_valid_out <= write_cmp && !cmp_rst_r;
      if (write_pcm) begin
        pcm_byte_out <= wdata_r;
      end
      if (write_cmp) begin
        compressed_byte_out <= wdata_r;
      end
      host_mode_out <= mode_w;
      // memory pins and autoboot reuse the pins that the parallel bus would occupy
      ext_memory_enable_out <= serial_mode(mode_w);
      autoboot_allowed_out <= serial_mode(mode_w);
    end
  end
endmodule

// ### rtl/host_port_defines.vh
// register map, control bit positions and mode codes of the byte-wide host port
// assumes inclusion by the host port and mode latch design files
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define ADDR_MESSAGE_PIPE 2'h0
`define ADDR_HOST_CONTROL_STATUS 2'h1
`define ADDR_PCM_INPUT_PORT 2'h2
`define ADDR_COMPRESSED_INPUT_PORT 2'h3
`define BIT_COMPRESSED_RESET 6
`define BIT_PCM_RESET 5
`define BIT_PCM_ALMOST_FULL 4
`define BIT_COMPRESSED_ALMOST_FULL 3
`define BIT_INBOUND_BUSY 2
`define BIT_OUTBOUND_READY 1
`define CHANNEL_RESET_INIT 1'b0
`define MODE_STROBE_DIR 3'h0
`define MODE_SEPARATE 3'h1
`define MODE_I2C 3'h2
`define MODE_SPI 3'h3
`define MODE_NONE 3'h4
`endif

// ### rtl/pin_sync.v
// three-flop synchroniser with agreement filter for a group of pins
// assumes asynchronous inputs; outside reset, output changes only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clock_in,
  input wire reset_n_in,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;
  integer i;

  // shift chain keeps running through reset, so strap pins are settled when reset lifts;
  // outside reset a bit moves only once stages two and three agree
  always @(posedge clock_in) begin
    stage1_r <= pin_in;
    stage2_r <= stage1_r;
    stage3_r <= stage2_r;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (!reset_n_in || stage2_r[i] == stage3_r[i]) begin
        level_out[i] <= stage3_r[i];
      end
    end
  end
endmodule

// ### rtl/mode_latch.v
// catches the host mode straps at reset release
// assumes straps arrive already synchronised
`timescale 1ns/1ps
`include "host_port_defines.vh"
module mode_latch (
  input wire clock_in,
  input wire reset_n_in,
  input wire read_strap_in,
  input wire write_strap_in,
  input wire select_strap_in,
  output reg [2:0] mode_out
);
  reg in_reset_r;

  // decode of the three strap pins into a mode code
  function [2:0] decode_mode;
    input rd;
    input wr;
    input ps;
    begin
      if (rd && wr) begin
        decode_mode = ps ? `MODE_STROBE_DIR : `MODE_SEPARATE;
      end else if (!rd && wr) begin
        decode_mode = `MODE_I2C;
      end else if (rd && !wr) begin
        decode_mode = `MODE_SPI;
      end else begin
        decode_mode = `MODE_NONE;
      end
    end
  endfunction

  // straps follow the pins during reset, freeze at the first edge after release
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      in_reset_r <= 1'b1;
      mode_out <= `MODE_NONE;
    end else begin
      in_reset_r <= 1'b0;
      if (in_reset_r) begin
        mode_out <= decode_mode(read_strap_in, write_strap_in, select_strap_in);
      end
    end
  end
endmodule

// ### tb/host_port_monitor.sv
// assertion checker for the byte-wide host port, bound to its top module
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`include "host_port_defines.vh"
module host_port_monitor (
  input wire clock_in,
  input wire reset_n_in,
  input wire chip_select_n_in,
  input wire write_strobe_n_in,
  input wire fw_inbound_read_in,
  input wire fw_outbound_write_in,
  input wire fw_message_waiting_in,
  input wire data_oe_n_out,
  input wire host_irq_n_oe_n_out,
  input wire inbound_busy_out,
  input wire outbound_ready_out,
  input wire pcm_channel_reset_out,
  input wire pcm_byte_valid_out,
  input wire [2:0] host_mode_out,
  input wire ext_memory_enable_out,
  input wire autoboot_allowed_out
);
  default clocking mon_clk @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // data bus stays released while leaving reset or while deselected
  property p_free_after_reset;
    !$past(reset_n_in) |-> data_oe_n_out;
  endproperty
  a_free_after_reset: assert property (p_free_after_reset) else $error("bus driven out of reset");
  property p_deselected;
    chip_select_n_in [*8] |-> data_oe_n_out;
  endproperty
  a_deselected: assert property (p_deselected) else $error("bus driven while deselected");
  // serial modes never touch the parallel bus and own the memory pins
  property p_serial_silent;
    (host_mode_out == `MODE_I2C || host_mode_out == `MODE_SPI) |-> data_oe_n_out;
  endproperty
  a_serial_silent: assert property (p_serial_silent) else $error("bus driven in serial mode");
  property p_ext_memory;
    $stable(host_mode_out) |-> ext_memory_enable_out == (host_mode_out == `MODE_I2C ||
      host_mode_out == `MODE_SPI) && autoboot_allowed_out == ext_memory_enable_out;
  endproperty
  a_ext_memory: assert property (p_ext_memory) else $error("memory or autoboot enable wrong");
  // a latched mode holds until the next reset
  property p_mode_held;
    host_mode_out != `MODE_NONE |=> $stable(host_mode_out);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode changed without reset");
  // message handshake flags and interrupt line follow the firmware side; a held pcm channel passes no bytes
  property p_inbound_clear;
    write_strobe_n_in [*8] ##0 fw_inbound_read_in |-> ##2 !inbound_busy_out;
  endproperty
  a_inbound_clear: assert property (p_inbound_clear) else $error("inbound busy not cleared");
  property p_outbound_set;
    fw_outbound_write_in |-> ##2 outbound_ready_out;
  endproperty
  a_outbound_set: assert property (p_outbound_set) else $error("outbound ready not set");
  property p_irq_follows;
    fw_message_waiting_in [*3] ##0 host_mode_out == `MODE_SEPARATE |-> !host_irq_n_oe_n_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt line not pulled");
  property p_pcm_held;
    pcm_channel_reset_out |-> !pcm_byte_valid_out;
  endproperty
  a_pcm_held: assert property (p_pcm_held) else $error("pcm byte passed while held");
endmodule

// ### tb/host_cpu_model.sv
// host processor model driving the byte-wide parallel bus
// assumes the bench collects results; sd selects strobe-plus-direction use
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic clock_in,
  input wire logic oe_n_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [1:0] addr_out,
  output logic [7:0] bus_out
);
  logic sd = 1'b0;
  // idle levels before the first cycle
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 2'h0;
    bus_out = 8'h00;
  end
  // one cycle: a read waits for the drive, a write holds six edges
  task automatic cycle(input logic w, input logic [1:0] a, input logic [7:0] d, input logic csf);
    integer i;
    @(negedge clock_in);
    addr_out = a;
    bus_out = w ? d : ~bus_out;
    if (sd) rd_n_out = !w;
    @(negedge clock_in);
    cs_n_out = 1'b0;
    if (sd || w) wr_n_out = 1'b0;
    else rd_n_out = 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_in);
      if (w ? i == 5 : !oe_n_in) break;
    end
    // select may rise one edge ahead of the strobe
    @(negedge clock_in);
    cs_n_out = 1'b1;
    if (csf) @(negedge clock_in);
    wr_n_out = 1'b1;
    if (!sd) rd_n_out = 1'b1;
    repeat (2) @(negedge clock_in);
    bus_out = ~bus_out; // hold over, lines no longer carry the byte
    rd_n_out = 1'b1;
    repeat (6) @(negedge clock_in);
  endtask
endmodule

// ### tb/byte_wide_host_port_bench.sv
// self-checking bench for the byte-wide host port
// assumes host_cpu_model as the host and the checker bound below
`timescale 1ns/1ps
`include "host_port_defines.vh"
module byte_wide_host_port_bench;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic parallel_select_in = 1'b0;
  logic fw_outbound_write_in = 1'b0;
  logic fw_inbound_read_in = 1'b0;
  logic fw_message_waiting_in = 1'b0;
  logic pcm_buffer_almost_full_in = 1'b0;
  logic compressed_buffer_almost_full_in = 1'b0;
  logic [7:0] fw_outbound_data_in = 8'h00;
  wire chip_select_n_in, read_strobe_n_in, write_strobe_n_in, data_oe_n_out, host_irq_n_oe_n_out;
  wire inbound_busy_out, outbound_ready_out, compressed_channel_reset_out, pcm_channel_reset_out;
  wire pcm_byte_valid_out, compressed_byte_valid_out, ext_memory_enable_out, autoboot_allowed_out;
  wire [1:0] reg_addr_in;
  wire [2:0] host_mode_out;
  wire [7:0] h_d, data_out, fw_inbound_data_out, pcm_byte_out, compressed_byte_out;
  wire [7:0] data_in = !data_oe_n_out ? data_out : h_d;
  logic [7:0] rd_q[$], pcm_q[$], cmp_q[$];
  logic [2:0] md[4] = '{`MODE_STROBE_DIR, `MODE_SEPARATE, `MODE_I2C, `MODE_SPI};
  logic [7:0] b, h;
  logic [1:0] af;
  logic oe_q = 1'b1;
  integer miscompares = 0, cmp_count = 0, i, seed;
  byte_wide_host_port DUT (.*);
  host_cpu_model u_host (.clock_in(clock_in), .oe_n_in(data_oe_n_out), .cs_n_out(chip_select_n_in),
    .rd_n_out(read_strobe_n_in), .wr_n_out(write_strobe_n_in), .addr_out(reg_addr_in), .bus_out(h_d));
  // 50 MHz clock
  always #10 clock_in = ~clock_in;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset with straps set and the host selecting throughout
  task automatic do_reset(input logic r, input logic w, input logic p);
    @(negedge clock_in);
    reset_n_in = 1'b0;
    parallel_select_in = p;
    u_host.rd_n_out = r;
    u_host.wr_n_out = w;
    u_host.cs_n_out = 1'b0;
    repeat (5) @(negedge clock_in);
    chk("oe_in_reset", 8'h01, 8'(data_oe_n_out));
    reset_n_in = 1'b1;
    repeat (3) @(negedge clock_in);
    u_host.cs_n_out = 1'b1;
    u_host.rd_n_out = 1'b1;
    u_host.wr_n_out = 1'b1;
    repeat (5) @(negedge clock_in);
  endtask
  task automatic fw_send(input logic [7:0] v);
    fw_outbound_data_in = v;
    fw_outbound_write_in = 1'b1;
    @(negedge clock_in);
    fw_outbound_write_in = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask
  // each result is matched with the oldest note when it appears
  always @(posedge clock_in) begin
    oe_q <= data_oe_n_out;
    if (!data_oe_n_out && oe_q)
      chk("read", rd_q.size() ? rd_q.pop_front() : 8'hxx, data_out);
    if (pcm_byte_valid_out)
      chk("pcm", pcm_q.size() ? pcm_q.pop_front() : 8'hxx, pcm_byte_out);
    if (compressed_byte_valid_out)
      chk("cmp", cmp_q.size() ? cmp_q.pop_front() : 8'hxx, compressed_byte_out);
  end
  initial begin
    seed = $urandom(70777);
    for (i = 0; i < 4; i++) begin
      do_reset(i != 2, i != 3, i == 0 ? 1'b1 : i == 1 ? 1'b0 : 1'($urandom));
      chk("mode", 8'(md[i]), 8'(host_mode_out));
      chk("xmem", i > 1 ? 8'h03 : 8'h00, 8'({ext_memory_enable_out, autoboot_allowed_out}));
      if (i > 1) u_host.cycle(1'b0, 2'h1, 8'h00, 1'b0);
    end
    do_reset(1'b1, 1'b1, 1'b0);
    af = 2'($urandom);
    {pcm_buffer_almost_full_in, compressed_buffer_almost_full_in} = af;
    rd_q.push_back({3'h0, af, 3'h0});
    u_host.cycle(1'b0, 2'h1, 8'h00, 1'b0);
    b = 8'($urandom);
    fw_send(b);
    chk("ready", 8'h01, 8'(outbound_ready_out));
    rd_q.push_back(b);
    u_host.cycle(1'b0, 2'h0, 8'h00, 1'b0);
    rd_q.push_back({3'h0, af, 3'h0});
    u_host.cycle(1'b0, 2'h1, 8'h00, 1'b0);
    h = 8'($urandom);
    u_host.cycle(1'b1, 2'h0, h, 1'b1);
    chk("inbound", h, fw_inbound_data_out);
    chk("busy", 8'h01, 8'(inbound_busy_out));
    rd_q.push_back({3'h0, af, 3'h4});
    u_host.cycle(1'b0, 2'h1, 8'h00, 1'b0);
    rd_q.push_back(b);
    u_host.cycle(1'b0, 2'h0, 8'h00, 1'b0);
    fw_inbound_read_in = 1'b1;
    @(negedge clock_in);
    fw_inbound_read_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk("busy", 8'h00, 8'(inbound_busy_out));
    // stream bytes to both input ports, then read them back as zero
    for (i = 0; i < 8; i++) begin
      h = 8'($urandom);
      if (i[0]) cmp_q.push_back(h);
      else pcm_q.push_back(h);
      u_host.cycle(1'b1, {1'b1, i[0]}, h, i[1]);
    end
    rd_q.push_back(8'h00);
    rd_q.push_back(8'h00);
    u_host.cycle(1'b0, 2'h2, 8'h00, 1'b0);
    u_host.cycle(1'b0, 2'h3, 8'h00, 1'b0);
    // hold both channels; their bytes must not pass
    u_host.cycle(1'b1, 2'h1, 8'h60, 1'b0);
    chk("chan_rst", 8'h03, 8'({compressed_channel_reset_out, pcm_channel_reset_out}));
    rd_q.push_back({3'h0, af, 3'h0});
    u_host.cycle(1'b0, 2'h1, 8'h00, 1'b0);
    u_host.cycle(1'b1, 2'h2, 8'h5a, 1'b0);
    u_host.cycle(1'b1, 2'h3, 8'ha5, 1'b0);
    u_host.cycle(1'b1, 2'h1, 8'h00, 1'b0);
    chk("chan_rst", 8'h00, 8'({compressed_channel_reset_out, pcm_channel_reset_out}));
    fw_message_waiting_in = 1'b1;
    repeat (6) @(negedge clock_in);
    chk("irq", 8'h00, 8'(host_irq_n_oe_n_out));
    fw_message_waiting_in = 1'b0;
    repeat (6) @(negedge clock_in);
    chk("irq", 8'h01, 8'(host_irq_n_oe_n_out));
    u_host.rd_n_out = 1'b0;
    repeat (10) @(negedge clock_in);
    chk("oe_deselected", 8'h01, 8'(data_oe_n_out));
    u_host.rd_n_out = 1'b1;
    // strobe-plus-direction write and read of the message pipe
    do_reset(1'b1, 1'b1, 1'b1);
    u_host.sd = 1'b1;
    h = 8'($urandom);
    u_host.cycle(1'b1, 2'h0, h, 1'b0);
    chk("inbound", h, fw_inbound_data_out);
    b = ~h;
    fw_send(b);
    rd_q.push_back(b);
    u_host.cycle(1'b0, 2'h0, 8'h00, 1'b1);
    u_host.sd = 1'b0;
    chk("pending", 8'h00, 8'(rd_q.size() + pcm_q.size() + cmp_q.size()));
    print_verdict;
  end
  // watchdog well beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    print_verdict;
  end
endmodule
bind byte_wide_host_port host_port_monitor u_mon (.*);
